// File: rtl/van_ctrl_pkg.sv
// constants for the vehicle bus controller configuration block
package van_ctrl_pkg;
  // register addresses on the core's special function bus
  localparam logic [15:0] ADDR_CONTROL = 16'hF802;
  localparam logic [15:0] ADDR_BUS_CONFIGURATION = 16'hF803;
  localparam logic [15:0] ADDR_DIAGNOSIS_SPEED_CONTROL = 16'hF804;
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_BUS_CONFIGURATION = 8'h08;
  localparam logic [7:0] RST_DIAGNOSIS_SPEED_CONTROL = 8'h17;
  // control register bits (set only)
  localparam int CTL_SOFT_RESET = 0;
  localparam int CTL_LAST_BYTE = 1;
  localparam int CTL_ACK_REQ = 2;
  localparam int CTL_STOP_TX = 3;
  // bus configuration bits
  localparam int CFG_MASK_ENABLE_LO = 0;
  localparam int CFG_MASK_ENABLE_HI = 1;
  localparam int CFG_IN_FRAME_RESPONSE_ENABLE = 2;
  localparam int CFG_RANK_SYNC = 3;
  localparam int CFG_IDENTIFIER_BIT_IRQ_ENABLE = 4;
  localparam logic [7:0] CFG_WRITABLE = 8'h1F;
  // diagnosis and speed control fields
  localparam int DSC_COMM_MODE_LO = 0;
  localparam int DSC_COMM_MODE_HI = 1;
  localparam int DSC_TX_DIAG_DISABLE = 2;
  localparam int DSC_DIAG_CLOCK_PULSE = 3;
  localparam int DSC_PRESCALE_LSB = 4;
  localparam logic [1:0] COMM_MODE_AUTO = 2'h3;
  // one network time slot lasts this many quartz clocks times the ratio
  localparam int TS_QUARTZ_CLOCKS = 16;
  localparam int PS_CNT_W = 9;
endpackage

// File: rtl/van_ctrl_config.sv
// control, configuration and bus-speed logic of the vehicle bus controller
`timescale 1ns/1ps
// How it works
// - final-byte flag set: two crc bytes follow that byte at once.
// - read frame with flag set and no response: crc after identifier two.
// - control bits set only by software, cleared by hardware; zero ignored.
// - software reset reinitialises like a hardware reset and also pulses frame abort.
// - configuration reads 08H after reset: synchronous, no in-frame reply.
// - identifier irq bit adds an interrupt at the 12th identifier bit.
// - rank bit 0 selects autonomous mode, 1 selects synchronous mode.
// - autonomous mode generates start-of-frame from the quartz clock.
// - in-frame response allowed only when its enable bit is one.
// - mask field 00 both masks, 01 no mask one, 10 no mask two, 11 none.
// - four-bit prescaler code in upper nibble of diagnosis register.
// - codes map to ratios 1,2,3,5,2,4,6,10,2,4,6,10,4,8,12,20.
// - time slot rate is quartz divided by sixteen times the ratio.
// - diagnosis register resets to 17H: prescaler code 1, disable set, mode 11.
// - mode 00,01,10 force receive line a,b,c; 11 is automatic.
// - transmit diagnosis enabled at 0; writing 1 pulses diagnosis clock.
module van_ctrl_config (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // core register port
  input wire logic [15:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // events from the frame shifter
  input wire logic byte_done,
  input wire logic response_missing,
  input wire logic id_bit12,
  input wire logic ack_taken,
  input wire logic frame_request,
  // frame control outputs
  output logic crc_insert,
  output logic byte_irq,
  output logic id12_irq,
  output logic sof_pulse,
  output logic ts_tick,
  output logic stop_transmit,
  output logic ack_request,
  output logic frame_abort,
  // configuration outputs
  output logic sync_mode,
  output logic ifr_allow,
  output logic mask1_active,
  output logic mask2_active,
  output logic [1:0] rx_line_sel,
  output logic auto_mode,
  output logic tx_diag_enable,
  output logic diag_clock
);
  typedef struct packed {
    logic [7:0] bus_configuration;
    logic [7:0] diagnosis_speed_control;
    logic soft_reset;
    logic last_byte;
    logic ack_req;
    logic stop_tx;
    logic [van_ctrl_pkg::PS_CNT_W-1:0] ps_cnt;
    logic sof_pending;
    logic [7:0] rdata;
    logic crc;
    logic byte_irq;
    logic id12_irq;
    logic sof;
    logic ts;
    logic stop_pulse;
    logic abort;
    logic diag_clk;
    logic sync;
    logic in_frame_response_enable;
    logic m1;
    logic m2;
    logic [1:0] rx_sel;
    logic auto;
    logic txd_en;
  } state_s;
  localparam state_s RST = '{
    bus_configuration: van_ctrl_pkg::RST_BUS_CONFIGURATION,
    diagnosis_speed_control: van_ctrl_pkg::RST_DIAGNOSIS_SPEED_CONTROL,
    rx_sel: van_ctrl_pkg::RST_DIAGNOSIS_SPEED_CONTROL[1:0],
    auto: 1'b1,
    sync: 1'b1,
    m1: 1'b1,
    m2: 1'b1,
    default: '0
  };
  function automatic logic [4:0] div_ratio(input logic [3:0] code);
    case (code)
      4'h0: div_ratio = 5'h01;
      4'h1: div_ratio = 5'h02;
      4'h2: div_ratio = 5'h03;
      4'h3: div_ratio = 5'h05;
      4'h4: div_ratio = 5'h02;
      4'h5: div_ratio = 5'h04;
      4'h6: div_ratio = 5'h06;
      4'h7: div_ratio = 5'h0A;
      4'h8: div_ratio = 5'h02;
      4'h9: div_ratio = 5'h04;
      4'hA: div_ratio = 5'h06;
      4'hB: div_ratio = 5'h0A;
      4'hC: div_ratio = 5'h04;
      4'hD: div_ratio = 5'h08;
      4'hE: div_ratio = 5'h0C;
      default: div_ratio = 5'h14;
    endcase
  endfunction
  state_s cur;
  state_s next_s;
  logic [van_ctrl_pkg::PS_CNT_W-1:0] slot_len;
  logic wr_ctl;
  logic wr_cfg;
  logic wr_dsc;
  always_comb begin
    wr_ctl = wr_en && addr == van_ctrl_pkg::ADDR_CONTROL;
    wr_cfg = wr_en && addr == van_ctrl_pkg::ADDR_BUS_CONFIGURATION;
    wr_dsc = wr_en && addr == van_ctrl_pkg::ADDR_DIAGNOSIS_SPEED_CONTROL;
    slot_len = van_ctrl_pkg::PS_CNT_W'(van_ctrl_pkg::TS_QUARTZ_CLOCKS
      * div_ratio(cur.diagnosis_speed_control[7:4]));
    next_s = cur;
    next_s.crc = 1'b0;
    next_s.sof = 1'b0;
    next_s.ts = 1'b0;
    next_s.stop_pulse = 1'b0;
    next_s.abort = 1'b0;
    next_s.diag_clk = 1'b0;
    next_s.byte_irq = byte_done;
    next_s.id12_irq = id_bit12 &&
      cur.bus_configuration[van_ctrl_pkg::CFG_IDENTIFIER_BIT_IRQ_ENABLE];
    // crc after last byte or missing reply
    if (cur.last_byte && (byte_done || response_missing)) begin
      next_s.crc = 1'b1;
      next_s.last_byte = 1'b0;
    end
    if (ack_taken) begin
      next_s.ack_req = 1'b0;
    end
    // stop request acts once, then clears itself
    if (cur.stop_tx) begin
      next_s.stop_pulse = 1'b1;
      next_s.stop_tx = 1'b0;
    end
    // set only; a set in the clearing cycle wins
    if (wr_ctl) begin
      if (wdata[van_ctrl_pkg::CTL_LAST_BYTE]) begin
        next_s.last_byte = 1'b1;
      end
      if (wdata[van_ctrl_pkg::CTL_ACK_REQ]) begin
        next_s.ack_req = 1'b1;
      end
      if (wdata[van_ctrl_pkg::CTL_STOP_TX]) begin
        next_s.stop_tx = 1'b1;
      end
      if (wdata[van_ctrl_pkg::CTL_SOFT_RESET]) begin
        next_s.soft_reset = 1'b1;
      end
    end
    if (wr_cfg) begin
      next_s.bus_configuration = wdata & van_ctrl_pkg::CFG_WRITABLE;
    end
    if (wr_dsc) begin
      // pulse bit never stores, so the next write can pulse again
      next_s.diagnosis_speed_control = wdata;
      next_s.diagnosis_speed_control[van_ctrl_pkg::DSC_DIAG_CLOCK_PULSE] =
        1'b0;
      next_s.diag_clk = wdata[van_ctrl_pkg::DSC_DIAG_CLOCK_PULSE];
    end
    // time slot divider; >= covers a speed change mid count
    if (cur.ps_cnt >= slot_len - 1'b1) begin
      next_s.ps_cnt = '0;
      next_s.ts = 1'b1;
    end else begin
      next_s.ps_cnt = cur.ps_cnt + 1'b1;
    end
    // autonomous start of frame on a slot boundary
    if (frame_request &&
        !cur.bus_configuration[van_ctrl_pkg::CFG_RANK_SYNC]) begin
      next_s.sof_pending = 1'b1;
    end
    if (cur.sof_pending && cur.ts) begin
      next_s.sof = 1'b1;
      next_s.sof_pending = 1'b0;
    end
    if (cur.bus_configuration[van_ctrl_pkg::CFG_RANK_SYNC]) begin
      next_s.sof_pending = 1'b0;
    end
    // registered copies of configuration for the frame logic
    next_s.sync = cur.bus_configuration[van_ctrl_pkg::CFG_RANK_SYNC];
    next_s.in_frame_response_enable =
      cur.bus_configuration[van_ctrl_pkg::CFG_IN_FRAME_RESPONSE_ENABLE];
    next_s.m1 = !cur.bus_configuration[van_ctrl_pkg::CFG_MASK_ENABLE_LO];
    next_s.m2 = !cur.bus_configuration[van_ctrl_pkg::CFG_MASK_ENABLE_HI];
    next_s.rx_sel = cur.diagnosis_speed_control[
      van_ctrl_pkg::DSC_COMM_MODE_HI:van_ctrl_pkg::DSC_COMM_MODE_LO];
    next_s.auto = next_s.rx_sel == van_ctrl_pkg::COMM_MODE_AUTO;
    next_s.txd_en =
      !cur.diagnosis_speed_control[van_ctrl_pkg::DSC_TX_DIAG_DISABLE];
    // read data, one cycle after the strobe
    if (rd_en) begin
      case (addr)
        van_ctrl_pkg::ADDR_CONTROL:
          next_s.rdata = {4'h0, cur.stop_tx, cur.ack_req, cur.last_byte,
                          cur.soft_reset};
        van_ctrl_pkg::ADDR_BUS_CONFIGURATION:
          next_s.rdata = cur.bus_configuration;
        van_ctrl_pkg::ADDR_DIAGNOSIS_SPEED_CONTROL:
          next_s.rdata = cur.diagnosis_speed_control;
        default: next_s.rdata = 8'h00;
      endcase
    end
    // software reset restores everything and aborts the frame
    if (cur.soft_reset) begin
      next_s = RST;
      next_s.abort = 1'b1;
    end
  end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= RST;
    end else begin
      cur <= next_s;
    end
  end
  assign rdata = cur.rdata;
  assign crc_insert = cur.crc;
  assign byte_irq = cur.byte_irq;
  assign id12_irq = cur.id12_irq;
  assign sof_pulse = cur.sof;
  assign ts_tick = cur.ts;
  assign stop_transmit = cur.stop_pulse;
  assign ack_request = cur.ack_req;
  assign frame_abort = cur.abort;
  assign sync_mode = cur.sync;
  assign ifr_allow = cur.in_frame_response_enable;
  assign mask1_active = cur.m1;
  assign mask2_active = cur.m2;
  assign rx_line_sel = cur.rx_sel;
  assign auto_mode = cur.auto;
  assign tx_diag_enable = cur.txd_en;
  assign diag_clock = cur.diag_clk;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // a new final-byte write in the same cycle wins over the clear
  a_crc_after_last:
    assert property (cur.last_byte && byte_done && !cur.soft_reset
      |=> crc_insert && (!cur.last_byte ||
      $past(wr_ctl && wdata[van_ctrl_pkg::CTL_LAST_BYTE])))
    else $error("crc not inserted after final byte");
  a_crc_no_reply:
    assert property (cur.last_byte && response_missing && !cur.soft_reset
      |=> crc_insert)
    else $error("crc not inserted on missing reply");
  a_zero_no_clear:
    assert property (cur.ack_req && wr_ctl && !ack_taken && !cur.soft_reset
      |=> ack_request)
    else $error("control bit cleared by write");
  a_soft_reset_all:
    assert property (cur.soft_reset |=> frame_abort &&
      cur.bus_configuration == van_ctrl_pkg::RST_BUS_CONFIGURATION &&
      cur.diagnosis_speed_control ==
      van_ctrl_pkg::RST_DIAGNOSIS_SPEED_CONTROL && !cur.last_byte)
    else $error("software reset incomplete");
  a_abort_sync_mode:
    assert property (frame_abort |=> sync_mode && !ifr_allow)
    else $error("reset config not synchronous");
  a_id12_gate:
    assert property (id_bit12 && !cur.soft_reset |=> id12_irq ==
      $past(cur.bus_configuration[van_ctrl_pkg::CFG_IDENTIFIER_BIT_IRQ_ENABLE]))
    else $error("identifier interrupt wrong");
  a_sof_sync_none:
    assert property (sync_mode && $past(sync_mode) |-> !sof_pulse)
    else $error("start of frame in synchronous mode");
  a_mask_follow:
    assert property (!cur.soft_reset |=> mask1_active ==
      !$past(cur.bus_configuration[van_ctrl_pkg::CFG_MASK_ENABLE_LO]))
    else $error("mask one select wrong");
  a_slot_spacing:
    assert property (ts_tick |=> !ts_tick [*8])
    else $error("time slots too close");
  a_diag_pulse:
    assert property (!cur.soft_reset |=> diag_clock ==
      $past(wr_dsc && wdata[van_ctrl_pkg::DSC_DIAG_CLOCK_PULSE]))
    else $error("diagnosis clock not one pulse per write");
  c_crc: cover property (cur.last_byte && byte_done ##1 crc_insert);
  c_sof: cover property (frame_request && !sync_mode ##[1:400] sof_pulse);
  c_soft: cover property (cur.soft_reset ##1 frame_abort);
endmodule

// File: bench/van_shifter_model.sv
// frame shifter stand-in: event pulses and a slow acknowledge handshake
`timescale 1ns/1ps
module van_shifter_model #(
  parameter int ACK_WAIT = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // bench side
  input wire logic [3:0] fire,
  // controller side
  input wire logic ack_request,
  output logic [3:0] events,
  output logic ack_taken
);
  int wait_cnt;
  // takes the acknowledge late so the held bit can be seen
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_cnt <= 0;
      ack_taken <= 1'b0;
      events <= 4'h0;
    end else begin
      // a requested event leaves the shifter one edge later
      events <= fire;
      wait_cnt <= ack_request ? wait_cnt + 1 : 0;
      ack_taken <= ack_request && wait_cnt == ACK_WAIT;
    end
  end
endmodule

// File: bench/van_bus_controller_config_tb_top.sv
// self-checking bench for the bus controller configuration block
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  $display("BAD %s exp %0h got %0h", n, e, g); miscompares++; end end
module van_bus_controller_config_tb_top;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, got;
  logic [3:0] events;
  logic [3:0] fire = 4'h0;
  logic ack_taken, crc_insert, byte_irq, id12_irq, sof_pulse, ts_tick;
  logic stop_transmit, ack_request, frame_abort, sync_mode, ifr_allow;
  logic mask1_active, mask2_active, auto_mode, tx_diag_enable, diag_clock;
  logic [1:0] rx_line_sel;
  logic [2:0] watch;
  logic [5:0] pulses;
  int cnt [6];
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  int ratio [16] = '{1, 2, 3, 5, 2, 4, 6, 10, 2, 4, 6, 10, 4, 8, 12, 20};
  assign watch = {sof_pulse, ts_tick, !ack_request};
  assign pulses = {frame_abort, diag_clock, id12_irq, byte_irq, crc_insert,
    stop_transmit};
  always #2.5 ref_clk = ~ref_clk;
  // pulses are counted so their exact cycle does not matter here
  always @(posedge ref_clk) begin
    for (int k = 0; k < 6; k++) begin
      cnt[k] += pulses[k];
    end
  end
  van_ctrl_config i_dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wr_en(wr_en),
    .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .byte_done(events[0]),
    .response_missing(events[1]), .id_bit12(events[2]),
    .ack_taken(ack_taken), .frame_request(events[3]),
    .crc_insert(crc_insert), .byte_irq(byte_irq), .id12_irq(id12_irq),
    .sof_pulse(sof_pulse), .ts_tick(ts_tick),
    .stop_transmit(stop_transmit), .ack_request(ack_request),
    .frame_abort(frame_abort), .sync_mode(sync_mode),
    .ifr_allow(ifr_allow), .mask1_active(mask1_active),
    .mask2_active(mask2_active), .rx_line_sel(rx_line_sel),
    .auto_mode(auto_mode), .tx_diag_enable(tx_diag_enable),
    .diag_clock(diag_clock)
  );
  van_shifter_model i_shift (
    .ref_clk(ref_clk), .arst_n(arst_n), .ack_request(ack_request),
    .fire(fire), .events(events), .ack_taken(ack_taken)
  );
  task automatic stop_test();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // waits two extra edges so derived outputs have settled
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge ref_clk);
    #1 wr_en = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge ref_clk);
    #1 addr = a;
    rd_en = 1'b1;
    @(posedge ref_clk);
    #1 rd_en = 1'b0;
    got = rdata;
  endtask
  // asks the shifter for one event; returns once the design has answered
  task automatic pulse(input int b);
    @(posedge ref_clk);
    #1 fire[b] = 1'b1;
    @(posedge ref_clk);
    #1 fire = 4'h0;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wait_bit(input int b, input int lim);
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
    end while (watch[b] !== 1'b1 && n < lim);
    if (watch[b] !== 1'b1) begin
      miscompares++;
      stop_test();
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    rd(16'hF802); `CHK("control", 8'h00, got)
    rd(16'hF803); `CHK("config", 8'h08, got)
    rd(16'hF804); `CHK("diag", 8'h17, got)
    rd(16'hF800); `CHK("unmapped", 8'h00, got)
    `CHK("sync", 1'b1, sync_mode)
    `CHK("ifr", 1'b0, ifr_allow)
    `CHK("masks", 2'h3, {mask2_active, mask1_active})
    `CHK("line", 2'h3, rx_line_sel)
    `CHK("txdiag", 1'b0, tx_diag_enable)
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(16'hF803, {4'h0, i[0], i[1], i[1:0]});
      `CHK("sync", i[0], sync_mode)
      `CHK("ifr", i[1], ifr_allow)
      `CHK("masks", ~i[1:0], {mask2_active, mask1_active})
      wr(16'hF804, {4'h0, 1'b0, i[0], i[1:0]});
      `CHK("line", i[1:0], rx_line_sel)
      `CHK("auto", i == 3, auto_mode)
      `CHK("txdiag", !i[0], tx_diag_enable)
    end
    $display("test config done");
    for (int c = 0; c < 16; c++) begin
      wr(16'hF804, {c[3:0], 4'h7});
      repeat (2) wait_bit(1, 400);
      wait_bit(1, 400);
      `CHK("period", 16 * ratio[c], n)
    end
    $display("test prescaler done");
    wr(16'hF804, 8'h0F);
    rd(16'hF804); `CHK("diag", 8'h07, got)
    for (int k = 0; k < 6; k++) begin
      cnt[k] = 0;
    end
    wr(16'hF802, 8'h02);
    pulse(0);
    `CHK("crc", 1'b1, crc_insert)
    pulse(0);
    rd(16'hF802); `CHK("control", 8'h00, got)
    wr(16'hF802, 8'h02);
    pulse(1);
    `CHK("crc", 1'b1, crc_insert)
    // the counter takes a pulse one edge after it rises
    wr(16'hF803, 8'h18);
    `CHK("crcs", 2, cnt[1])
    `CHK("byte irqs", 2, cnt[2])
    pulse(2);
    wr(16'hF803, 8'h08);
    pulse(2);
    `CHK("id irqs", 1, cnt[3])
    $display("test frame done");
    wr(16'hF802, 8'h0C);
    `CHK("ack", 1'b1, ack_request)
    wr(16'hF802, 8'h00);
    `CHK("ack", 1'b1, ack_request)
    wait_bit(0, 20);
    `CHK("stops", 1, cnt[0])
    `CHK("diag clk", 0, cnt[4])
    wr(16'hF804, 8'h0F);
    `CHK("diag clk", 1, cnt[4])
    wr(16'hF803, 8'h00);
    pulse(3);
    wait_bit(2, 40);
    `CHK("sof", 1'b1, sof_pulse)
    $display("test control done");
    wr(16'hF803, 8'h1F);
    wr(16'hF802, 8'h01);
    rd(16'hF803); `CHK("config", 8'h08, got)
    rd(16'hF804); `CHK("diag", 8'h17, got)
    `CHK("aborts", 1, cnt[5])
    $display("test soft reset done");
    stop_test();
  end
endmodule
